// ==== inc/rri_pkg.sv ====
package rri_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (word index, byte address is index times four)
  localparam int         NREG           = 26;
  localparam int         ADDR_W         = 7;
  localparam logic [4:0] IDX_PTR1_HIGH  = 5'h00;
  localparam logic [4:0] IDX_PTR1_LOW   = 5'h01;
  localparam logic [4:0] IDX_BANK       = 5'h02;
  localparam logic [4:0] IDX_PTR2_HIGH  = 5'h03;
  localparam logic [4:0] IDX_PTR2_LOW   = 5'h04;
  localparam logic [4:0] IDX_ALU_FLAGS  = 5'h05;
  localparam logic [4:0] IDX_T0_HIGH    = 5'h06;
  localparam logic [4:0] IDX_T0_LOW     = 5'h07;
  localparam logic [4:0] IDX_T0_CTRL    = 5'h08;
  localparam logic [4:0] IDX_OSC_CTRL   = 5'h09;
  localparam logic [4:0] IDX_LVD_CTRL   = 5'h0a;
  localparam logic [4:0] IDX_WDOG_CTRL  = 5'h0b;
  localparam logic [4:0] IDX_CAUSE      = 5'h0c;
  localparam logic [4:0] IDX_T1_HIGH    = 5'h0d;
  localparam logic [4:0] IDX_T1_LOW     = 5'h0e;
  localparam logic [4:0] IDX_T1_CTRL    = 5'h0f;
  localparam logic [4:0] IDX_T2_COUNT   = 5'h10;
  localparam logic [4:0] IDX_T2_PERIOD  = 5'h11;
  localparam logic [4:0] IDX_T2_CTRL    = 5'h12;
  localparam logic [4:0] IDX_TOP_UPPER  = 5'h13;
  localparam logic [4:0] IDX_TOP_HIGH   = 5'h14;
  localparam logic [4:0] IDX_TOP_LOW    = 5'h15;
  localparam logic [4:0] IDX_STACK_PTR  = 5'h16;
  localparam logic [4:0] IDX_IRQ_CTRL   = 5'h17;
  localparam logic [4:0] IDX_PA_LATCH   = 5'h18;
  localparam logic [4:0] IDX_PA_DIR     = 5'h19;
  localparam logic [4:0] IDX_PA_PINS    = 5'h1a;

  ////////////////////////////////////////////////////////////////////////////
  // per-register images, index 0 first
  localparam logic [7:0] IMPL_MASK [NREG] = '{
    8'h0f, 8'hff, 8'h0f, 8'h0f, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h3f, 8'h01, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h1f,
    8'hff, 8'hff, 8'hdf, 8'hff, 8'hff, 8'hdf};
  localparam logic [7:0] POR_VAL [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
    8'h05, 8'h00, 8'h1c, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hdf};
  localparam logic [7:0] POR_KEEP [NREG] = '{
    8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h1f, 8'h00, 8'hff, 8'h00, 8'h10,
    8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RST_KEEP [NREG] = '{
    8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h1f, 8'h00, 8'hff, 8'h00, 8'h40,
    8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hbf, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hc0, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] WAKE_KEEP [NREG] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] RO_MASK [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int         CAUSE_IPEN     = 5;
  localparam int         CAUSE_INSTR    = 4;
  localparam int         CAUSE_TIMEOUT  = 3;
  localparam int         CAUSE_PWRDN    = 2;
  localparam int         CAUSE_PWRON    = 1;
  localparam int         CAUSE_BROWN    = 0;
  localparam int         STK_FULL_BIT   = 7;
  localparam int         STK_UNF_BIT    = 6;
  localparam int         OSC_STAT_BIT   = 1;
  localparam int         IRQ_HIGH_EN    = 7;
  localparam int         IRQ_LOW_EN     = 6;
  localparam logic [7:0] IRQ_SRC_MASK   = 8'h3f;
  localparam logic [7:0] PA_FIXED_MASK  = 8'h3f;
  localparam logic [7:0] PA_OSC_MASK    = 8'hc0;
  localparam logic [4:0] STK_PTR_MAX    = 5'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // program counter values
  localparam logic [20:0] VEC_RESET     = 21'h0_0000;
  localparam logic [20:0] VEC_HIGH      = 21'h0_0008;
  localparam logic [20:0] VEC_LOW       = 21'h0_0018;
  localparam logic [20:0] WAKE_STEP     = 21'h0_0002;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [3:0] {
    CAUSE_NONE      = 4'h0,
    CAUSE_BOR       = 4'h1,
    CAUSE_PIN       = 4'h2,
    CAUSE_WDOG_RST  = 4'h3,
    CAUSE_INSTR_RST = 4'h4,
    CAUSE_STK_FULL  = 4'h5,
    CAUSE_STK_UNF   = 4'h6,
    CAUSE_UNF_ERR   = 4'h7,
    CAUSE_WDOG_WAKE = 4'h8,
    CAUSE_IRQ_WAKE  = 4'h9
  } rri_cause_t;

  typedef enum logic [0:0] {
    BUS_IDLE   = 1'h0,
    BUS_ANSWER = 1'h1
  } rri_bus_state_t;

  function automatic logic [7:0] rri_apply(input logic [7:0] cur,
                                           input logic [7:0] val,
                                           input logic [7:0] keep,
                                           input logic [7:0] impl);
    return ((cur & keep) | (val & ~keep)) & impl;
  endfunction : rri_apply

endpackage : rri_pkg

// ==== hdl/rri_sync.sv ====
`timescale 1ns/1ps
module rri_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // asynchronous input and its synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } rri_sync_state_t;

  rri_sync_state_t s_reg;
  rri_sync_state_t s_next;

  always_comb begin
    s_next        = s_reg;
    s_next.stage1 = d;
    s_next.stage2 = s_reg.stage1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.stage2;

endmodule : rri_sync

// ==== hdl/rri_cause_decode.sv ====
`timescale 1ns/1ps
module rri_cause_decode
  import rri_pkg::*;
(
  // event pulses
  input  wire logic brown_out,
  input  wire logic pin_reset,
  input  wire logic watchdog_timeout,
  input  wire logic reset_instr,
  input  wire logic stack_full,
  input  wire logic stack_underflow,
  input  wire logic irq_wake,
  // conditions
  input  wire logic core_sleeping,
  input  wire logic stack_fault_reset_enable,
  // decoded cause
  output rri_cause_t cause
);

  // one cause per cycle; resets before wake-ups, except that a watchdog wake outranks watchdog and instruction resets
  always_comb begin
    cause = CAUSE_NONE;
    if (brown_out) begin
      cause = CAUSE_BOR;
    end else if (pin_reset) begin
      cause = CAUSE_PIN;
    end else if (stack_full && stack_fault_reset_enable) begin
      cause = CAUSE_STK_FULL;
    end else if (stack_underflow && stack_fault_reset_enable) begin
      cause = CAUSE_STK_UNF;
    end else if (watchdog_timeout && core_sleeping) begin
      cause = CAUSE_WDOG_WAKE;
    end else if (watchdog_timeout) begin
      cause = CAUSE_WDOG_RST;
    end else if (reset_instr) begin
      cause = CAUSE_INSTR_RST;
    end else if (stack_underflow) begin
      cause = CAUSE_UNF_ERR;
    end else if (irq_wake && core_sleeping) begin
      cause = CAUSE_IRQ_WAKE;
    end
  end

endmodule : rri_cause_decode

// ==== hdl/rri_register_reset_initializer.sv ====
// Function
// - unimplemented bits ignore writes, read zero, except port A pins bit 5, which reads the pin
// - unchanged bits keep value; unknown bits untouched
// - interrupt wake with enable loads vector
// - interrupt wake with enable pushes counter onto stack top
// - interrupt wake with enable advances hardware stack pointer, holding at 1f
// - interrupt wake sets source flag bits
// - port A bits 6,7 only when oscillator frees
// - cause flags follow the actual event
// - underflow without fault reset only sets flag
// - watchdog in sleep wakes, counter plus two
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module rri_register_reset_initializer
  import rri_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // reset and wake events
  input  wire logic        brown_out,
  input  wire logic        external_reset_pin_n,
  input  wire logic        watchdog_timeout,
  input  wire logic        reset_instr,
  input  wire logic        stack_full,
  input  wire logic        stack_underflow,
  input  wire logic        irq_wake,
  input  wire logic        irq_wake_high,
  input  wire logic [5:0]  wake_sources,
  // core conditions
  input  wire logic        core_sleeping,
  input  wire logic        stack_fault_reset_enable,
  input  wire logic        osc_frees_port_pins,
  input  wire logic        osc_running,
  // program counter
  input  wire logic [20:0] program_counter_in,
  output logic      [20:0] program_counter_out,
  output logic             program_counter_load,
  output logic             core_reset,
  // port A
  input  wire logic [7:0]  port_a_pins_in,
  output logic      [7:0]  port_a_out,
  output logic      [7:0]  port_a_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    rri_bus_state_t       bus_state;
    logic                 wait_req;
    logic [31:0]          rdata;
    logic [20:0]          jump_target;
    logic                 jump_load;
    logic                 core_reset;
    logic [7:0]           pa_out;
    logic [7:0]           pa_oe;
    logic                 pin_prev;
  } rri_state_t;

  rri_state_t s_reg;
  rri_state_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and cause decode

  logic       pin_sync;
  logic [7:0] pa_pins_sync;
  logic       pin_reset;
  rri_cause_t cause;

  rri_sync #(
    .W (1)
  ) u_pin_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (external_reset_pin_n),
    .q       (pin_sync)
  );

  rri_sync #(
    .W (8)
  ) u_port_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (port_a_pins_in),
    .q       (pa_pins_sync)
  );

  // falling edge of the synchronised pin
  assign pin_reset = s_reg.pin_prev & ~pin_sync;

  rri_cause_decode u_decode (
    .brown_out                (brown_out),
    .pin_reset                (pin_reset),
    .watchdog_timeout         (watchdog_timeout),
    .reset_instr              (reset_instr),
    .stack_full               (stack_full),
    .stack_underflow          (stack_underflow),
    .irq_wake                 (irq_wake),
    .core_sleeping            (core_sleeping),
    .stack_fault_reset_enable (stack_fault_reset_enable),
    .cause                    (cause)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic       bus_req;
  logic [4:0] bus_idx;
  logic       bus_mapped;
  logic [7:0] pa_mask;
  logic       cls_bor;
  logic       cls_reset;
  logic       cls_wake;
  logic [7:0] cause_flags;
  logic [7:0] stk;
  logic [7:0] wr_cause;
  logic       irq_vector_en;

  assign bus_req    = avs_read | avs_write;
  assign bus_idx    = avs_address[6:2];
  assign bus_mapped = bus_idx < 5'(NREG);
  assign pa_mask    = PA_FIXED_MASK | (osc_frees_port_pins ? PA_OSC_MASK : 8'h00);
  assign cls_bor    = cause == CAUSE_BOR;
  assign cls_reset  = (cause == CAUSE_PIN) || (cause == CAUSE_WDOG_RST) ||
                      (cause == CAUSE_INSTR_RST) || (cause == CAUSE_STK_FULL) ||
                      (cause == CAUSE_STK_UNF);
  assign cls_wake   = (cause == CAUSE_WDOG_WAKE) || (cause == CAUSE_IRQ_WAKE);

  always_comb begin
    s_next           = s_reg;
    s_next.jump_load = 1'h0;
    s_next.core_reset = 1'h0;
    s_next.pin_prev  = pin_sync;
    cause_flags      = 8'h00;
    stk              = 8'h00;
    wr_cause         = 8'h00;
    irq_vector_en    = 1'h0;

    // bus handshake: answer one cycle after the request
    unique case (s_reg.bus_state)
      BUS_IDLE: begin
        if (bus_req) begin
          s_next.bus_state = BUS_ANSWER;
          s_next.wait_req  = 1'h0;
          if (avs_read && bus_idx == IDX_PA_PINS) begin
            s_next.rdata = {24'h00_0000, pa_pins_sync & pa_mask};
          end else if (avs_read && bus_mapped) begin
            s_next.rdata = {24'h00_0000, s_reg.regs[bus_idx] & IMPL_MASK[bus_idx]};
          end else begin
            s_next.rdata = 32'h0000_0000;
          end
        end
      end
      BUS_ANSWER: begin
        s_next.bus_state = BUS_IDLE;
        s_next.wait_req  = 1'h1;
        if (avs_write && bus_mapped) begin
          s_next.regs[bus_idx] = ((s_reg.regs[bus_idx] & RO_MASK[bus_idx]) |
                                  (avs_writedata[7:0] & ~RO_MASK[bus_idx])) &
                                 IMPL_MASK[bus_idx];
        end
      end
    endcase

    // cause value as software left it this cycle
    wr_cause = s_next.regs[IDX_CAUSE];

    // class images; events override a write in the same cycle, except in the bits that their image keeps
    for (int i = 0; i < NREG; i++) begin
      if (cls_bor) begin
        s_next.regs[i] = rri_apply(s_next.regs[i], POR_VAL[i], POR_KEEP[i],
                                   IMPL_MASK[i]);
      end else if (cls_reset) begin
        s_next.regs[i] = rri_apply(s_next.regs[i], POR_VAL[i], RST_KEEP[i],
                                   IMPL_MASK[i]);
      end else if (cls_wake) begin
        s_next.regs[i] = rri_apply(s_next.regs[i], POR_VAL[i], WAKE_KEEP[i],
                                   IMPL_MASK[i]);
      end
    end

    cause_flags = s_next.regs[IDX_CAUSE];
    stk         = s_next.regs[IDX_STACK_PTR];

    // cause-dependent flag bits
    if (cls_reset) begin
      cause_flags[CAUSE_IPEN] = 1'h0;
    end
    unique case (cause)
      CAUSE_BOR: begin
        cause_flags[CAUSE_PWRON] = wr_cause[CAUSE_PWRON];
      end
      CAUSE_PIN: begin
        cause_flags[CAUSE_TIMEOUT] = 1'h1;
        if (core_sleeping) begin
          cause_flags[CAUSE_PWRDN] = 1'h0;
        end
      end
      CAUSE_WDOG_RST: begin
        cause_flags[CAUSE_TIMEOUT] = 1'h0;
      end
      CAUSE_INSTR_RST: begin
        cause_flags[CAUSE_INSTR] = 1'h0;
      end
      CAUSE_STK_FULL: begin
        stk[STK_FULL_BIT] = 1'h1;
      end
      CAUSE_STK_UNF: begin
        stk[STK_UNF_BIT] = 1'h1;
      end
      CAUSE_UNF_ERR: begin
        stk[STK_UNF_BIT] = 1'h1;
      end
      CAUSE_WDOG_WAKE: begin
        cause_flags[CAUSE_TIMEOUT] = 1'h0;
        cause_flags[CAUSE_PWRDN]   = 1'h0;
        s_next.jump_target         = program_counter_in + WAKE_STEP;
        s_next.jump_load           = 1'h1;
      end
      CAUSE_IRQ_WAKE: begin
        cause_flags[CAUSE_PWRDN] = 1'h0;
        s_next.regs[IDX_IRQ_CTRL] = s_next.regs[IDX_IRQ_CTRL] |
                                    ({2'h0, wake_sources} & IRQ_SRC_MASK);
        irq_vector_en = s_next.regs[IDX_IRQ_CTRL][IRQ_HIGH_EN] |
                        s_next.regs[IDX_IRQ_CTRL][IRQ_LOW_EN];
        s_next.jump_load = 1'h1;
        if (irq_vector_en) begin
          s_next.jump_target = (irq_wake_high && s_next.regs[IDX_IRQ_CTRL][IRQ_HIGH_EN]) ?
                               VEC_HIGH : VEC_LOW;
          s_next.regs[IDX_TOP_UPPER] = {3'h0, program_counter_in[20:16]};
          s_next.regs[IDX_TOP_HIGH]  = program_counter_in[15:8];
          s_next.regs[IDX_TOP_LOW]   = program_counter_in[7:0];
          if (stk[4:0] != STK_PTR_MAX) begin
            stk[4:0] = stk[4:0] + 5'h01;
          end
          if (stk[4:0] == STK_PTR_MAX) begin
            stk[STK_FULL_BIT] = 1'h1;
          end
        end else begin
          s_next.jump_target = program_counter_in + WAKE_STEP;
        end
      end
      default: begin
      end
    endcase

    // oscillator status follows the clock after any reset or wake
    if (cls_bor || cls_reset || cls_wake) begin
      s_next.regs[IDX_OSC_CTRL][OSC_STAT_BIT] = osc_running;
    end
    if (cls_bor || cls_reset) begin
      s_next.jump_target = VEC_RESET;
      s_next.jump_load   = 1'h1;
      s_next.core_reset  = 1'h1;
    end

    s_next.regs[IDX_CAUSE]     = cause_flags & IMPL_MASK[IDX_CAUSE];
    s_next.regs[IDX_STACK_PTR] = stk & IMPL_MASK[IDX_STACK_PTR];

    // port A upper pins exist only when the oscillator frees them
    s_next.regs[IDX_PA_LATCH] = s_next.regs[IDX_PA_LATCH] & pa_mask;
    s_next.regs[IDX_PA_DIR]   = s_next.regs[IDX_PA_DIR] & pa_mask;
    s_next.pa_out = s_next.regs[IDX_PA_LATCH] & pa_mask;
    s_next.pa_oe  = ~s_next.regs[IDX_PA_DIR] & IMPL_MASK[IDX_PA_DIR] & pa_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; power-on image loads under reset

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_reg <= '0;
      for (int i = 0; i < NREG; i++) begin
        s_reg.regs[i] <= POR_VAL[i];
      end
      s_reg.bus_state  <= BUS_IDLE;
      s_reg.wait_req   <= 1'h1;
      s_reg.core_reset <= 1'h1;
      s_reg.pin_prev   <= 1'h1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata         = s_reg.rdata;
  assign avs_waitrequest      = s_reg.wait_req;
  assign program_counter_out  = s_reg.jump_target;
  assign program_counter_load = s_reg.jump_load;
  assign core_reset           = s_reg.core_reset;
  assign port_a_out           = s_reg.pa_out;
  assign port_a_oe            = s_reg.pa_oe;

endmodule : rri_register_reset_initializer

// ==== bench/rri_register_reset_initializer_asserts.sv ====
`timescale 1ns/1ps
module rri_register_reset_initializer_asserts
  import rri_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // events and conditions
  input wire logic        brown_out,
  input wire logic        external_reset_pin_n,
  input wire logic        watchdog_timeout,
  input wire logic        reset_instr,
  input wire logic        stack_full,
  input wire logic        stack_underflow,
  input wire logic        irq_wake,
  input wire logic        core_sleeping,
  input wire logic        stack_fault_reset_enable,
  input wire logic        osc_frees_port_pins,
  // program counter and port
  input wire logic [20:0] program_counter_in,
  input wire logic [20:0] program_counter_out,
  input wire logic        program_counter_load,
  input wire logic        core_reset,
  input wire logic [7:0]  port_a_out,
  input wire logic [7:0]  port_a_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  wire logic busy_ev = brown_out || watchdog_timeout || reset_instr || stack_full || stack_underflow;

  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  reset_core_a: assert property ((reset_instr || brown_out || (stack_full && stack_fault_reset_enable)
    || (watchdog_timeout && !core_sleeping)) |=> core_reset && program_counter_out == VEC_RESET)
    else $error("reset event did not reset core");
  wdog_wake_a: assert property (watchdog_timeout && core_sleeping && !brown_out && !stack_full
    && !stack_underflow |=> program_counter_load && !core_reset
    && program_counter_out == $past(program_counter_in) + WAKE_STEP)
    else $error("watchdog wake target wrong");
  irq_vector_a: assert property (irq_wake && core_sleeping && !busy_ev |=> program_counter_load
    && !core_reset && (program_counter_out == VEC_HIGH || program_counter_out == VEC_LOW
    || program_counter_out == $past(program_counter_in) + WAKE_STEP))
    else $error("interrupt wake target wrong");
  unf_flag_a: assert property (stack_underflow && !stack_fault_reset_enable && !brown_out
    && !watchdog_timeout && !reset_instr && !stack_full |=> !core_reset && !program_counter_load)
    else $error("underflow without fault reset disturbed core");
  pin_reset_a: assert property ($fell(external_reset_pin_n) |-> ##[1:4] core_reset)
    else $error("pin reset not seen");
  port_mask_a: assert property (!osc_frees_port_pins && !$past(osc_frees_port_pins)
    && !$past(osc_frees_port_pins, 2) |-> port_a_out[7:6] == 2'b00 && port_a_oe[7:6] == 2'b00)
    else $error("port bits 6,7 active while not freed");
endmodule : rri_register_reset_initializer_asserts

bind rri_register_reset_initializer rri_register_reset_initializer_asserts i_chk (
  .clk(clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .brown_out(brown_out),
  .external_reset_pin_n(external_reset_pin_n), .watchdog_timeout(watchdog_timeout),
  .reset_instr(reset_instr), .stack_full(stack_full), .stack_underflow(stack_underflow),
  .irq_wake(irq_wake), .core_sleeping(core_sleeping),
  .stack_fault_reset_enable(stack_fault_reset_enable), .osc_frees_port_pins(osc_frees_port_pins),
  .program_counter_in(program_counter_in), .program_counter_out(program_counter_out),
  .program_counter_load(program_counter_load), .core_reset(core_reset),
  .port_a_out(port_a_out), .port_a_oe(port_a_oe));

// ==== bench/rri_register_reset_initializer_bench.sv ====
`timescale 1ns/1ps
module rri_register_reset_initializer_bench
  import rri_pkg::*;
;
  logic        clk, reset_n, avs_read, avs_write, avs_waitrequest, pin_n, wake_high;
  logic        sleeping, fault_en, frees, osc_run, pc_load, core_reset;
  logic [6:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, tmp;
  logic [5:0]  ev, wake_src;
  logic [20:0] pc_in, pc_out;
  logic [7:0]  pins, pa_out, pa_oe, kp;
  int          num_errors, n_compared, i, k;

  rri_register_reset_initializer i_dut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .brown_out(ev[0]), .external_reset_pin_n(pin_n),
    .watchdog_timeout(ev[1]), .reset_instr(ev[2]), .stack_full(ev[3]),
    .stack_underflow(ev[4]), .irq_wake(ev[5]), .irq_wake_high(wake_high),
    .wake_sources(wake_src), .core_sleeping(sleeping), .stack_fault_reset_enable(fault_en),
    .osc_frees_port_pins(frees), .osc_running(osc_run), .program_counter_in(pc_in),
    .program_counter_out(pc_out), .program_counter_load(pc_load), .core_reset(core_reset),
    .port_a_pins_in(pins), .port_a_out(pa_out), .port_a_oe(pa_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    avs_address   <= {idx, 2'b00};
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= {24'h00_0000, wd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    tmp = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) chk(32'h0000_0001, 32'h0000_0000);
  endtask : bus

  task automatic rd(input logic [4:0] idx, input logic [7:0] exp, input logic [7:0] m);
    bus(1'b0, idx, 8'h00);
    chk(tmp & {24'hff_ffff, m}, {24'h00_0000, exp & m});
  endtask : rd

  // one-cycle event pulse, returns where its effect is settled
  task automatic fire(input logic [5:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 6'h00;
    @(negedge clk);
  endtask : fire

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #(40 * 20000);
    num_errors++;
    $display("[FAIL] %0t: run hung", $time);
    complete_run();
  end

  initial begin
    {avs_read, avs_write, wake_high, sleeping, reset_n} = 5'h00;
    {pin_n, fault_en, frees, osc_run} = 4'hf;
    avs_address = 7'h00;
    avs_writedata = 32'h0000_0000;
    ev = 6'h00;
    wake_src = 6'h05;
    pc_in = 21'h0_1234;
    pins = 8'ha5;
    num_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 0; i < NREG; i++) rd(i[4:0], POR_VAL[i], IMPL_MASK[i] & ~RO_MASK[i] & ~POR_KEEP[i]);
    for (i = 0; i < NREG; i++) bus(1'b1, i[4:0], 8'hff);
    bus(1'b1, 5'd27, 8'hff);
    for (i = 0; i < NREG; i++) rd(i[4:0], IMPL_MASK[i], ~RO_MASK[i]);
    rd(5'd27, 8'h00, 8'hff);
    fire(6'h04);
    chk({31'h0, core_reset}, 32'h0000_0001);
    for (i = 0; i < NREG; i++) begin
      kp = RST_KEEP[i];
      if (i != IDX_CAUSE) rd(i[4:0], (IMPL_MASK[i] & kp) | (POR_VAL[i] & ~kp), ~RO_MASK[i]);
    end
    rd(IDX_CAUSE, 8'h0f, 8'hff);
    rd(IDX_OSC_CTRL, 8'h02, 8'h02);
    sleeping <= 1'b1;
    fire(6'h02);
    chk({11'h000, pc_out}, 32'h0000_1236);
    chk({30'h0, pc_load, core_reset}, 32'h0000_0002);
    rd(IDX_CAUSE, 8'h03, 8'hff);
    rd(IDX_PTR1_LOW, 8'hff, 8'hff);
    rd(IDX_T2_PERIOD, 8'hff, 8'hff);
    sleeping <= 1'b0;
    pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    pin_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd(IDX_CAUSE, 8'h0b, 8'hff);
    sleeping <= 1'b1;
    pc_in <= 21'h1_2345;
    bus(1'b1, IDX_STACK_PTR, 8'h00);
    for (k = 0; k < 3; k++) begin
      bus(1'b1, IDX_IRQ_CTRL, (k == 2) ? 8'h00 : 8'h80 >> k);
      wake_high <= (k == 0);
      fire(6'h20);
      chk({11'h000, pc_out}, {11'h000, (k == 0) ? VEC_HIGH : (k == 1) ? VEC_LOW : 21'h1_2347});
      rd(IDX_STACK_PTR, (k == 0) ? 8'h01 : 8'h02, 8'hff);
      rd(IDX_IRQ_CTRL, ((k == 2) ? 8'h00 : 8'h80 >> k) | 8'h05, 8'hff);
    end
    rd(IDX_TOP_UPPER, 8'h01, 8'h1f);
    rd(IDX_TOP_HIGH, 8'h23, 8'hff);
    rd(IDX_TOP_LOW, 8'h45, 8'hff);
    sleeping <= 1'b0;
    bus(1'b1, IDX_PA_DIR, 8'h00);
    bus(1'b1, IDX_PA_LATCH, 8'hff);
    @(negedge clk);
    // bit 5 has no direction bit, so it never drives
    chk({16'h0000, pa_out, pa_oe}, 32'h0000_ffdf);
    rd(IDX_PA_PINS, 8'ha5, 8'hff);
    @(posedge clk) frees <= 1'b0;
    repeat (3) @(negedge clk);
    chk({16'h0000, pa_out, pa_oe}, 32'h0000_3f1f);
    rd(IDX_PA_LATCH, 8'h3f, 8'hff);
    rd(IDX_PA_PINS, 8'h25, 8'hff);
    fault_en <= 1'b0;
    bus(1'b1, IDX_STACK_PTR, 8'h00);
    fire(6'h10);
    chk({30'h0, pc_load, core_reset}, 32'h0000_0000);
    rd(IDX_STACK_PTR, 8'h40, 8'hff);
    rd(IDX_CAUSE, 8'h0b, 8'hff);
    fault_en <= 1'b1;
    fire(6'h08);
    chk({10'h000, core_reset, pc_out}, {10'h000, 1'b1, VEC_RESET});
    rd(IDX_STACK_PTR, 8'hc0, 8'hff);
    osc_run <= 1'b0;
    fire(6'h01);
    rd(IDX_CAUSE, 8'h1e, 8'hff);
    rd(IDX_OSC_CTRL, 8'h00, 8'h02);
    complete_run();
  end
endmodule : rri_register_reset_initializer_bench
